// *** logic/iprb_top.sv ***
// priority level register bank 4..8 with axi4-lite slave
// assumes synchronous reset; levels feed an external arbiter
//
// Functional notes
// - code 111 gives level seven, highest
// - code 001 gives level one, lowest
// - code 000 disables the source entirely
// - bits 15, 11, 7, 3 read zero
// - bank 4: oc3, ic8, ic7, ext1 fields
// - bank 5: ext2, timer5, timer4, oc4 fields
// - bank 6: can1, spi2, uart2 tx, rx
// - bank 7: input capture 6,5,4,3 fields
// - bank 8: output compare 8,7,6,5 fields
// - fields read back last written value
// - all fields reset to level four
`timescale 1ns/1ps
`default_nettype none
module iprb_top
    import iprb_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [2:0] out_compare_three_level,
    output logic [2:0] in_capture_eight_level,
    output logic [2:0] in_capture_seven_level,
    output logic [2:0] ext_pin_one_level,
    output logic [2:0] ext_pin_two_level,
    output logic [2:0] timer_five_level,
    output logic [2:0] timer_four_level,
    output logic [2:0] out_compare_four_level,
    output logic [2:0] can_one_combined_level,
    output logic [2:0] serial_periph_two_level,
    output logic [2:0] uart_two_transmit_level,
    output logic [2:0] uart_two_receive_level,
    output logic [2:0] in_capture_six_level,
    output logic [2:0] in_capture_five_level,
    output logic [2:0] in_capture_four_level,
    output logic [2:0] in_capture_three_level,
    output logic [2:0] out_compare_eight_level,
    output logic [2:0] out_compare_seven_level,
    output logic [2:0] out_compare_six_level,
    output logic [2:0] out_compare_five_level,
    output logic [NUM_SOURCES-1:0] source_enabled
);
    // -------------------------------------------------------------
    // storage
    // -------------------------------------------------------------
    logic [15:0] bank_ff [NUM_BANKS];
    logic [2:0] level_ff [NUM_SOURCES];
    logic [NUM_SOURCES-1:0] enabled_ff;
    logic [2:0] dec_level [NUM_SOURCES];
    logic [NUM_SOURCES-1:0] dec_enabled;

    // -------------------------------------------------------------
    // write channel
    // -------------------------------------------------------------
    iprb_wstate_t wstate_ff;
    logic aw_held_ff;
    logic w_held_ff;
    logic [4:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic aw_take;
    logic w_take;
    logic do_write;
    logic [4:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_hit;
    logic [2:0] wr_idx;

    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign wr_addr = aw_held_ff ? awaddr_ff : s_axi_awaddr;
    assign wr_data = w_held_ff ? wdata_ff : s_axi_wdata;
    assign wr_strb = w_held_ff ? wstrb_ff : s_axi_wstrb;
    assign do_write = (wstate_ff == IPRB_W_IDLE)
        && (aw_held_ff || aw_take) && (w_held_ff || w_take);

    always_comb
    begin
        wr_hit = 1'b1;
        wr_idx = 3'h0;
        case (wr_addr)
            ADDR_BANK_4: wr_idx = 3'h0;
            ADDR_BANK_5: wr_idx = 3'h1;
            ADDR_BANK_6: wr_idx = 3'h2;
            ADDR_BANK_7: wr_idx = 3'h3;
            ADDR_BANK_8: wr_idx = 3'h4;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= 5'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end
        else
        begin
            if (aw_take && !do_write)
            begin
                aw_held_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            else if (do_write)
            begin
                aw_held_ff <= 1'b0;
            end
            if (w_take && !do_write)
            begin
                w_held_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            else if (do_write)
            begin
                w_held_ff <= 1'b0;
            end
            s_axi_awready <= (wstate_ff == IPRB_W_IDLE) && !do_write
                && !(aw_held_ff || aw_take);
            s_axi_wready <= (wstate_ff == IPRB_W_IDLE) && !do_write
                && !(w_held_ff || w_take);
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wstate_ff <= IPRB_W_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            case (wstate_ff)
                IPRB_W_IDLE:
                begin
                    if (do_write)
                    begin
                        wstate_ff <= IPRB_W_RESP;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
                    end
                end
                IPRB_W_RESP:
                begin
                    if (s_axi_bready)
                    begin
                        s_axi_bvalid <= 1'b0;
                        wstate_ff <= IPRB_W_HOLD;
                    end
                end
                IPRB_W_HOLD:
                begin
                    wstate_ff <= IPRB_W_IDLE;
                end
                default:
                begin
                    wstate_ff <= IPRB_W_IDLE;
                    s_axi_bvalid <= 1'b0;
                end
            endcase
        end
    end

    // -------------------------------------------------------------
    // register bank
    // -------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            for (int b = 0; b < NUM_BANKS; b++)
            begin
                bank_ff[b] <= BANK_RESET;
            end
        end
        else if (do_write && wr_hit)
        begin
            if (wr_strb[0])
            begin
                // unimplemented bits never stored
                bank_ff[wr_idx][7:0] <= wr_data[7:0] & IMPL_MASK[7:0];
            end
            if (wr_strb[1])
            begin
                bank_ff[wr_idx][15:8] <= wr_data[15:8] & IMPL_MASK[15:8];
            end
        end
    end

    // -------------------------------------------------------------
    // read channel
    // -------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_rvalid)
        begin
            s_axi_arready <= 1'b0;
            if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            // readback of stored fields, zero above
            case (s_axi_araddr)
                ADDR_BANK_4: s_axi_rdata <= {16'h0000, bank_ff[0]};
                ADDR_BANK_5: s_axi_rdata <= {16'h0000, bank_ff[1]};
                ADDR_BANK_6: s_axi_rdata <= {16'h0000, bank_ff[2]};
                ADDR_BANK_7: s_axi_rdata <= {16'h0000, bank_ff[3]};
                ADDR_BANK_8: s_axi_rdata <= {16'h0000, bank_ff[4]};
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end
        else
        begin
            s_axi_arready <= 1'b1;
        end
    end

    // -------------------------------------------------------------
    // field decode, one per source
    // -------------------------------------------------------------
    for (genvar s = 0; s < NUM_SOURCES; s++)
    begin : g_src
        iprb_field_if fif ();
        localparam int LSB = (s % NUM_FIELDS) * (FIELD_1_LSB - FIELD_0_LSB);
        assign fif.code = bank_ff[s / NUM_FIELDS][LSB +: FIELD_W];
        assign dec_level[s] = fif.level;
        assign dec_enabled[s] = fif.enabled;
        iprb_field_dec u_dec (.fld(fif));
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            for (int s = 0; s < NUM_SOURCES; s++)
            begin
                level_ff[s] <= LEVEL_RESET;
            end
            enabled_ff <= '1;
        end
        else
        begin
            for (int s = 0; s < NUM_SOURCES; s++)
            begin
                level_ff[s] <= dec_level[s];
            end
            enabled_ff <= dec_enabled;
        end
    end

    // -------------------------------------------------------------
    // source mapping, index = bank*4 + field (field 0 = bits 2-0)
    // -------------------------------------------------------------
    assign ext_pin_one_level = level_ff[0];
    assign in_capture_seven_level = level_ff[1];
    assign in_capture_eight_level = level_ff[2];
    assign out_compare_three_level = level_ff[3];
    assign out_compare_four_level = level_ff[4];
    assign timer_four_level = level_ff[5];
    assign timer_five_level = level_ff[6];
    assign ext_pin_two_level = level_ff[7];
    assign uart_two_receive_level = level_ff[8];
    assign uart_two_transmit_level = level_ff[9];
    assign serial_periph_two_level = level_ff[10];
    assign can_one_combined_level = level_ff[11];
    assign in_capture_three_level = level_ff[12];
    assign in_capture_four_level = level_ff[13];
    assign in_capture_five_level = level_ff[14];
    assign in_capture_six_level = level_ff[15];
    assign out_compare_five_level = level_ff[16];
    assign out_compare_six_level = level_ff[17];
    assign out_compare_seven_level = level_ff[18];
    assign out_compare_eight_level = level_ff[19];
    assign source_enabled = enabled_ff;
endmodule : iprb_top
`default_nettype wire

// *** logic/iprb_pkg.sv ***
// package for the priority level register bank 4..8
// assumes a 32-bit axi4-lite register bus, one aligned word per register
`default_nettype none
package iprb_pkg;
    // -------------------------------------------------------------
    // register map
    // -------------------------------------------------------------
    localparam logic [4:0] ADDR_BANK_4 = 5'h00;
    localparam logic [4:0] ADDR_BANK_5 = 5'h04;
    localparam logic [4:0] ADDR_BANK_6 = 5'h08;
    localparam logic [4:0] ADDR_BANK_7 = 5'h0C;
    localparam logic [4:0] ADDR_BANK_8 = 5'h10;
    localparam int NUM_BANKS = 5;
    localparam int NUM_FIELDS = 4;
    localparam int NUM_SOURCES = 20;
    // -------------------------------------------------------------
    // field layout
    // -------------------------------------------------------------
    localparam int FIELD_W = 3;
    localparam int FIELD_0_LSB = 0;
    localparam int FIELD_1_LSB = 4;
    localparam int FIELD_2_LSB = 8;
    localparam int FIELD_3_LSB = 12;
    localparam logic [15:0] IMPL_MASK = 16'h7777;
    localparam logic [2:0] LEVEL_RESET = 3'h4;
    localparam logic [15:0] BANK_RESET = 16'h4444;
    localparam logic [2:0] LEVEL_OFF = 3'h0;
    localparam logic [2:0] LEVEL_MIN = 3'h1;
    localparam logic [2:0] LEVEL_MAX = 3'h7;
    // -------------------------------------------------------------
    // bus answers
    // -------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0]
    {
        IPRB_W_IDLE = 3'b001,
        IPRB_W_RESP = 3'b010,
        IPRB_W_HOLD = 3'b100
    } iprb_wstate_t;
endpackage : iprb_pkg
`default_nettype wire

// *** logic/iprb_field_if.sv ***
// carrier between the bank and its field decoders
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
interface iprb_field_if;
    logic [2:0] code;
    logic [2:0] level;
    logic enabled;
    modport bank (output code, input level, input enabled);
    modport dec (input code, output level, output enabled);
endinterface : iprb_field_if
`default_nettype wire

// *** logic/iprb_field_dec.sv ***
// decodes one 3-bit priority code into level and enable
// assumes a registered consumer in the same clock domain
`timescale 1ns/1ps
`default_nettype none
module iprb_field_dec
    import iprb_pkg::*;
(
    iprb_field_if.dec fld
);
    always_comb
    begin
        // code 000 gates the source off
        fld.enabled = (fld.code != LEVEL_OFF);
        // 001 lowest, 111 highest, middle codes map straight
        fld.level = fld.enabled ? fld.code : LEVEL_OFF;
    end
endmodule : iprb_field_dec
`default_nettype wire

// *** test/iprb_checker.sv ***
// checker for the priority bank bus handshakes and level ports
// assumes binding onto iprb_top, one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module iprb_checker
    import iprb_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] ext_pin_one_level,
    input wire logic [2:0] out_compare_eight_level,
    input wire logic [NUM_SOURCES-1:0] source_enabled
);
    // ------------------------------------------------------------
    // sequences and properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    reset_level_a: assert property (
        $fell(reset) |-> ext_pin_one_level == LEVEL_RESET
        && out_compare_eight_level == LEVEL_RESET && &source_enabled)
        else $error("levels not at reset value");
    bank4_low_a: assert property (
        wr_take ##0 (s_axi_awaddr == ADDR_BANK_4 && s_axi_wstrb[0])
        |-> ##2 ext_pin_one_level == $past(s_axi_wdata[2:0], 2))
        else $error("low field of bank 4 not applied");
    bank8_high_a: assert property (
        wr_take ##0 (s_axi_awaddr == ADDR_BANK_8 && s_axi_wstrb[1])
        |-> ##2 out_compare_eight_level == $past(s_axi_wdata[14:12], 2))
        else $error("high field of bank 8 not applied");
    source_off_a: assert property (
        source_enabled[0] == (ext_pin_one_level != LEVEL_OFF)
        && source_enabled[19] == (out_compare_eight_level != LEVEL_OFF))
        else $error("enable does not follow level");
    write_answer_a: assert property (
        wr_take |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("write response missing");
    b_release_a: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && !s_axi_awready)
        else $error("write response not released");
    unmapped_write_a: assert property (
        wr_take ##0 (s_axi_awaddr >= 5'h14) |=> s_axi_bresp == RESP_SLVERR
        ##1 $stable(ext_pin_one_level) && $stable(out_compare_eight_level))
        else $error("unmapped write misanswered");
    read_clean_a: assert property (
        rd_take |=> s_axi_rvalid && (s_axi_rdata & 32'hFFFF8888) == 32'h0)
        else $error("read data has unimplemented bits set");
    r_release_a: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data not released");
endmodule : iprb_checker
bind iprb_top iprb_checker chk (.clk, .reset, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .ext_pin_one_level,
    .out_compare_eight_level, .source_enabled);
`default_nettype wire

// *** test/iprb_top_bench.sv ***
// bench for the priority bank: axi4-lite tasks and level checks
// assumes iprb_top with the checker bound beside it
`timescale 1ns/1ps
`default_nettype none
module iprb_top_bench
    import iprb_pkg::*;
();
    logic clk, reset;
    logic [4:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [NUM_SOURCES-1:0] source_enabled, exp_en;
    wire [59:0] lv;
    logic [59:0] exp_lv;
    logic [15:0] exp_bank [NUM_BANKS];
    logic [4:0] adr [NUM_BANKS];
    int miscompares, checked;
    iprb_top uut (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .source_enabled,
        .ext_pin_one_level(lv[2:0]), .in_capture_seven_level(lv[5:3]),
        .in_capture_eight_level(lv[8:6]),
        .out_compare_three_level(lv[11:9]),
        .out_compare_four_level(lv[14:12]), .timer_four_level(lv[17:15]),
        .timer_five_level(lv[20:18]), .ext_pin_two_level(lv[23:21]),
        .uart_two_receive_level(lv[26:24]),
        .uart_two_transmit_level(lv[29:27]),
        .serial_periph_two_level(lv[32:30]),
        .can_one_combined_level(lv[35:33]),
        .in_capture_three_level(lv[38:36]),
        .in_capture_four_level(lv[41:39]),
        .in_capture_five_level(lv[44:42]), .in_capture_six_level(lv[47:45]),
        .out_compare_five_level(lv[50:48]), .out_compare_six_level(lv[53:51]),
        .out_compare_seven_level(lv[56:54]),
        .out_compare_eight_level(lv[59:57]));
    // ------------------------------------------------------------
    // clock, tasks
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [31:0] v,
        input logic [3:0] s);
        logic aw, w, b;
        aw = 1'b1;
        w = 1'b1;
        b = 1'b1;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw || w || b)
        begin
            @(posedge clk);
            if (b && s_axi_bvalid) rsp = s_axi_bresp;
            b = b && !s_axi_bvalid;
            aw = aw && !s_axi_awready;
            w = w && !s_axi_wready;
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
            s_axi_bready <= b;
        end
    endtask : wr
    task automatic rdr(input logic [4:0] a);
        logic ar, r;
        ar = 1'b1;
        r = 1'b1;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (ar || r)
        begin
            @(posedge clk);
            if (r && s_axi_rvalid) rd = s_axi_rdata;
            if (r && s_axi_rvalid) rsp = s_axi_rresp;
            r = r && !s_axi_rvalid;
            ar = ar && !s_axi_arready;
            s_axi_arvalid <= ar;
            s_axi_rready <= r;
        end
    endtask : rdr
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize
    initial
    begin
        repeat (5000) @(posedge clk);
        miscompares++;
        summarize();
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        adr = '{ADDR_BANK_4, ADDR_BANK_5, ADDR_BANK_6, ADDR_BANK_7,
            ADDR_BANK_8};
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        reset = 1'b1;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        for (int b = 0; b < NUM_BANKS; b++)
        begin
            rdr(adr[b]);
            chk(rd, BANK_RESET);
            chk(rsp, RESP_OKAY);
        end
        chk(lv, {20{LEVEL_RESET}});
        chk(source_enabled, {NUM_SOURCES{1'b1}});
        $display("test 1 done");
        // every code 0..7 lands in some field; noise in unused bits
        for (int b = 0; b < NUM_BANKS; b++)
        begin
            d = 32'hFFFF8888;
            for (int k = 0; k < NUM_FIELDS; k++)
            begin
                d[4*k+:3] = 3'((4*b+k) % 8);
                exp_lv[12*b+3*k+:3] = 3'((4*b+k) % 8);
            end
            exp_bank[b] = d[15:0] & 16'h7777;
            wr(adr[b], d, 4'hF);
            chk(rsp, RESP_OKAY);
        end
        for (int i = 0; i < NUM_SOURCES; i++)
            exp_en[i] = |exp_lv[3*i+:3];
        // levels settle one clock after the last write lands
        @(negedge clk);
        chk(lv, exp_lv);
        chk(source_enabled, exp_en);
        $display("test 2 done");
        wr(adr[2], 32'h0, 4'h1);
        exp_bank[2][7:0] = 8'h00;
        wr(adr[3], 32'h0, 4'h2);
        exp_bank[3][15:8] = 8'h00;
        wr(5'h14, 32'h0, 4'hF);
        chk(rsp, RESP_SLVERR);
        rdr(5'h14);
        chk(rsp, RESP_SLVERR);
        chk(rd, 32'h0);
        for (int b = 0; b < NUM_BANKS; b++)
        begin
            rdr(adr[b]);
            chk(rd, {16'h0, exp_bank[b]});
        end
        $display("test 3 done");
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rdr(adr[4]);
        chk(rd, BANK_RESET);
        chk(lv, {20{LEVEL_RESET}});
        $display("test 4 done");
        summarize();
    end
endmodule : iprb_top_bench
`default_nettype wire
